// ===== sysint_defs.svh
`ifndef SYSINT_DEFS_SVH
`define SYSINT_DEFS_SVH
// Register byte addresses (chosen)
`define ADDR_STATUS_A 12'h000
`define ADDR_STATUS_B 12'h004
`define ADDR_STATUS_C 12'h008
`define ADDR_RESET_CAUSE 12'h00C
`define ADDR_CONTROL 12'h010
`define ADDR_VECTOR 12'h014
// Reset cause fields
`define CAUSE_LOW_VOLTAGE 1
`define CAUSE_BUS 2
// Control fields
`define CTL_BUS_ENABLE 0
`define CTL_BUS_RESET_OFF 1
`define CTL_BUS_RESET_IRQ 2
`define CTL_SHORT_RECOVERY 3
`define CTL_RESET 8'h01
// Timing
`define LONG_CYCLES 12'hFFF
`define SHORT_CYCLES 12'h01F
`define TAIL_CYCLES 6'h1F
`define SE0_NS 2500
`define CLK_NS 10
`define ADDRESS_MS 10
// Vectors
`define VEC_RESET 16'hFFFE
`define VEC_SWI 16'hFFFC
`define VEC_TOP 16'hFFFA
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== sysint_pkg.sv
package sysint_pkg;
    typedef enum logic [4:0] {
        ST_RUN = 5'b0_0001,
        ST_PIN_LOW = 5'b0_0010,
        ST_TAIL = 5'b0_0100,
        ST_STOP = 5'b0_1000,
        ST_RECOVER = 5'b1_0000
    } seq_state_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
    } reg_write_t;
endpackage : sysint_pkg

// ===== reset_counter_interrupt_arbiter.sv
`timescale 1ns/1ps
`include "sysint_defs.svh"
module reset_counter_interrupt_arbiter #(
    parameter int LONG_COUNT = 4128 // Pin-low cycles, 4096 + 32
) (
    input wire logic clk_in, // 100 MHz clock
    input wire logic reset_in, // Sync reset, active high
    input wire logic low_voltage_in, // Low voltage detector, async
    input wire logic reset_pin_in, // Reset pin level, async
    output logic reset_pin_out, // Reset pin drive value (low)
    output logic reset_pin_oe_out, // Reset pin enable, high drives
    output logic core_reset_out, // Internal reset to core
    input wire logic dp_in, // Bus data plus, async
    input wire logic dm_in, // Bus data minus, async
    output logic bus_unaddressed_out, // Attached, not yet addressed
    output logic bus_irq_out, // Bus reset routed to IRQ
    output logic watchdog_tick_out, // Counter overflow pulse
    input wire logic stop_in, // Stop instruction executed
    input wire logic wake_in, // Wake by interrupt/break/reset
    output logic clocks_run_out, // Core clocks enabled
    input wire logic [15:1] request_in, // Live request lines
    input wire logic [15:1] enable_in, // Source enables
    input wire logic boundary_in, // Instruction boundary
    input wire logic mask_in, // Interrupt mask bit
    input wire logic swi_in, // Software interrupt instruction
    input wire logic serviced_in, // Vector fetched by core
    input wire logic [15:0] pc_in, // Current program counter
    output logic take_out, // Start interrupt entry
    output logic [15:0] vector_out, // Vector to fetch
    output logic [15:0] stacked_pc_out, // PC value to stack
    output logic stack_upper_index_out, // Upper index pushed
    output logic set_mask_out, // Set mask at entry
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready // Read ready
);
    localparam int SE0_CYCLES = (`SE0_NS + `CLK_NS - 1) / `CLK_NS + 1;
    localparam int ADDR_CYCLES = `ADDRESS_MS * 1000000 / `CLK_NS;

    sysint_pkg::seq_state_t state;
    logic [1:0] lv_sync, pin_sync, dp_sync, dm_sync;
    logic [11:0] counter;
    logic [12:0] long_count;
    logic [5:0] tail_count;
    logic [8:0] se0_count;
    logic bus_reset;
    logic [20:0] addr_timer;
    logic [7:0] control;
    logic [7:0] reset_cause;
    logic [15:0] latched_vec;
    logic latched;
    logic recovery_short;

    // Two-stage synchronisers; first stage is read by the second only
    always_ff @(posedge clk_in) begin
        lv_sync <= {lv_sync[0], low_voltage_in};
        pin_sync <= {pin_sync[0], reset_pin_in};
        dp_sync <= {dp_sync[0], dp_in};
        dm_sync <= {dm_sync[0], dm_in};
    end

    // Priority encoder: lowest flag number is highest priority
    function automatic logic [15:0] vector_of(input logic [15:1] pend);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 15; i >= 1; i--) begin
            if (pend[i]) begin
                v = `VEC_TOP - 16'(2 * (i - 1));
            end
        end
        return v;
    endfunction : vector_of

    wire [15:1] eligible = request_in & enable_in;
    wire bus_reset_chip = bus_reset && !control[`CTL_BUS_RESET_OFF] && !control[`CTL_BUS_RESET_IRQ];

    // Reset sequencer: pin-low phase, tail, stop and recovery
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= sysint_pkg::ST_TAIL;
            long_count <= 13'h0000;
            tail_count <= 6'h00;
        end else begin
            case (state)
                sysint_pkg::ST_RUN: begin
                    if (lv_sync[1] || bus_reset_chip) begin
                        state <= sysint_pkg::ST_PIN_LOW;
                        long_count <= lv_sync[1] ? 13'(LONG_COUNT - 1) : 13'(`TAIL_CYCLES);
                    end else if (stop_in) begin
                        state <= sysint_pkg::ST_STOP;
                    end
                end
                sysint_pkg::ST_PIN_LOW: begin
                    if (long_count == 13'h0000) begin
                        state <= sysint_pkg::ST_TAIL;
                        tail_count <= `TAIL_CYCLES;
                    end else begin
                        long_count <= long_count - 13'h0001;
                    end
                end
                sysint_pkg::ST_TAIL: begin
                    if (tail_count == 6'h00) begin
                        state <= sysint_pkg::ST_RUN;
                    end else begin
                        tail_count <= tail_count - 6'h01;
                    end
                end
                sysint_pkg::ST_STOP: begin
                    if (wake_in) begin
                        state <= sysint_pkg::ST_RECOVER;
                    end
                end
                sysint_pkg::ST_RECOVER: begin
                    if (counter == (recovery_short ? `SHORT_CYCLES : `LONG_CYCLES)) begin
                        state <= sysint_pkg::ST_RUN;
                    end
                end
                default: state <= sysint_pkg::ST_TAIL;
            endcase
        end
    end

    // Short recovery option sampled at wake
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            recovery_short <= 1'b0;
        end else if (state == sysint_pkg::ST_STOP && wake_in) begin
            recovery_short <= control[`CTL_SHORT_RECOVERY];
        end
    end

    // Free counter; pin reset deliberately does not touch it
    always_ff @(posedge clk_in) begin
        if (reset_in || state == sysint_pkg::ST_STOP || (state == sysint_pkg::ST_RUN && stop_in)) begin
            counter <= 12'h000;
        end else begin
            counter <= counter + 12'h001;
        end
    end

    // Overflow pulse prescales the watchdog
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            watchdog_tick_out <= 1'b0;
        end else begin
            watchdog_tick_out <= (counter == 12'hFFF) && state != sysint_pkg::ST_STOP;
        end
    end

    // Pin and core reset drive
    always_comb begin
        reset_pin_out = 1'b0;
        reset_pin_oe_out = (state == sysint_pkg::ST_PIN_LOW);
        core_reset_out = (state == sysint_pkg::ST_PIN_LOW) || (state == sysint_pkg::ST_TAIL);
        clocks_run_out = (state == sysint_pkg::ST_RUN);
    end

    // Bus SE0 filter, inhibited while the module is disabled
    always_ff @(posedge clk_in) begin
        if (reset_in || !control[`CTL_BUS_ENABLE] || dp_sync[1] || dm_sync[1]) begin
            se0_count <= 9'h000;
            bus_reset <= 1'b0;
        end else if (se0_count == 9'(SE0_CYCLES)) begin
            bus_reset <= 1'b1;
        end else begin
            se0_count <= se0_count + 9'h001;
        end
    end

    // Unaddressed flag set by bus reset and then held; window timer counts down after bus reset ends
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            addr_timer <= 21'h00_0000;
            bus_unaddressed_out <= 1'b0;
            bus_irq_out <= 1'b0;
        end else begin
            bus_irq_out <= bus_reset && control[`CTL_BUS_RESET_IRQ] && !control[`CTL_BUS_RESET_OFF];
            if (bus_reset) begin
                bus_unaddressed_out <= 1'b1;
                addr_timer <= 21'(ADDR_CYCLES);
            end else if (addr_timer != 21'h00_0000) begin
                addr_timer <= addr_timer - 21'h00_0001;
            end
        end
    end

    // Latch and arbitration at entry
    always_ff @(posedge clk_in) begin
        if (reset_in || core_reset_out) begin
            latched <= 1'b0;
            latched_vec <= `VEC_RESET;
        end else if (latched) begin
            if (serviced_in || !mask_in) begin
                latched <= 1'b0;
            end
        end else if (boundary_in && (swi_in || (!mask_in && eligible != 15'h0000))) begin
            latched <= 1'b1;
            latched_vec <= swi_in ? `VEC_SWI : vector_of(eligible);
        end
    end

    // Entry outputs to the core
    always_comb begin
        take_out = latched;
        vector_out = core_reset_out ? `VEC_RESET : latched_vec;
        stacked_pc_out = (latched_vec == `VEC_SWI) ? pc_in : pc_in - 16'h0001;
        stack_upper_index_out = 1'b0;
        set_mask_out = latched;
    end

    // AXI4-Lite write path
    logic aw_held, w_held;
    sysint_pkg::reg_write_t wr;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            control <= `CTL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr.data <= s_axi_wdata;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (wr.addr)
                    `ADDR_CONTROL: control <= wr.data[7:0];
                    `ADDR_STATUS_A, `ADDR_STATUS_B, `ADDR_STATUS_C, `ADDR_RESET_CAUSE, `ADDR_VECTOR: ;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Reset cause flags; a new cause wins over a read clear
    wire cause_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_RESET_CAUSE;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reset_cause <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (i == `CAUSE_LOW_VOLTAGE && state == sysint_pkg::ST_RUN && lv_sync[1]) begin
                    reset_cause[i] <= 1'b1;
                end else if (i == `CAUSE_BUS && state == sysint_pkg::ST_RUN && bus_reset_chip) begin
                    reset_cause[i] <= 1'b1;
                end else if (cause_read) begin
                    reset_cause[i] <= 1'b0;
                end
            end
        end
    end

    // AXI4-Lite read path
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `ADDR_STATUS_A: s_axi_rdata <= {24'h00_0000, request_in[6:1], 2'b00};
                `ADDR_STATUS_B: s_axi_rdata <= {24'h00_0000, request_in[14:7]};
                `ADDR_STATUS_C: s_axi_rdata <= {31'h0000_0000, request_in[15]};
                `ADDR_RESET_CAUSE: s_axi_rdata <= {24'h00_0000, reset_cause};
                `ADDR_CONTROL: s_axi_rdata <= {24'h00_0000, control};
                `ADDR_VECTOR: s_axi_rdata <= {16'h0000, latched_vec};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    sequence s_pin_phase;
        reset_pin_oe_out [*8];
    endsequence
    property p_pin_then_core;
        @(posedge clk_in) disable iff (reset_in) $fell(reset_pin_oe_out) |-> core_reset_out [*8];
    endproperty
    a_pin_then_core: assert property (p_pin_then_core) else $error("core released too early");
    property p_lv_starts;
        @(posedge clk_in) disable iff (reset_in) (state == sysint_pkg::ST_RUN && lv_sync[1]) |=> s_pin_phase;
    endproperty
    a_lv_starts: assert property (p_lv_starts) else $error("low voltage pin phase short");
    property p_lv_flag;
        @(posedge clk_in) disable iff (reset_in) (state == sysint_pkg::ST_RUN && lv_sync[1]) |=> reset_cause[`CAUSE_LOW_VOLTAGE];
    endproperty
    a_lv_flag: assert property (p_lv_flag) else $error("low voltage flag missing");
    property p_pin_low;
        @(posedge clk_in) disable iff (reset_in) reset_pin_oe_out |-> core_reset_out && !reset_pin_out;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin not driven low");
    property p_inhibit;
        @(posedge clk_in) disable iff (reset_in) !control[`CTL_BUS_ENABLE] |=> !bus_reset;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("bus reset while disabled");
    property p_stop_clear;
        @(posedge clk_in) disable iff (reset_in) (state == sysint_pkg::ST_RUN && stop_in && !lv_sync[1] && !bus_reset_chip) |=> counter == 12'h000;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear counter");
    property p_free_run;
        @(posedge clk_in) disable iff (reset_in) state == sysint_pkg::ST_RUN && $past(state) == sysint_pkg::ST_RUN |-> counter == $past(counter) + 12'h001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("counter not free running");
    property p_hold;
        @(posedge clk_in) disable iff (reset_in || core_reset_out) latched && !serviced_in && mask_in |=> latched && $stable(latched_vec);
    endproperty
    a_hold: assert property (p_hold) else $error("latched request preempted");
    property p_status_a;
        @(posedge clk_in) disable iff (reset_in) s_axi_rvalid |-> s_axi_rdata[1:0] == 2'b00 || $past(s_axi_araddr) != `ADDR_STATUS_A;
    endproperty
    a_status_a: assert property (p_status_a) else $error("status A low bits set");
    property p_swi_pc;
        @(posedge clk_in) disable iff (reset_in) latched && latched_vec == `VEC_SWI |-> stacked_pc_out == pc_in;
    endproperty
    a_swi_pc: assert property (p_swi_pc) else $error("software stacked wrong pc");
endmodule : reset_counter_interrupt_arbiter

// ===== core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire logic clk_in, // Oscillator clock
    input wire logic reset_in, // Sync reset, active high
    input wire logic take_in, // Entry request from arbiter
    input wire logic run_in, // Let instructions retire
    input wire logic hold_mask_in, // Software keeps mask set
    output logic boundary_out, // Instruction boundary pulse
    output logic serviced_out, // Vector fetch pulse
    output logic mask_out // Interrupt mask bit
);
    logic [2:0] phase;
    logic [3:0] isr; // Cycles left in service routine

    // Boundary every eighth cycle, none while a routine runs
    always_ff @(posedge clk_in) begin
        phase <= reset_in ? 3'h0 : phase + 3'h1;
        boundary_out <= !reset_in && run_in && phase == 3'h7 && isr == 4'h0;
    end

    // Fetch the vector one cycle after entry, then run a short routine
    always_ff @(posedge clk_in) begin
        serviced_out <= 1'h0;
        if (reset_in) begin
            isr <= 4'h0;
        end else if (take_in && !serviced_out && isr == 4'h0) begin
            serviced_out <= 1'h1;
            isr <= 4'hC;
        end else if (isr != 4'h0) begin
            isr <= isr - 4'h1;
        end
    end

    // Mask set on entry, dropped again on return
    assign mask_out = hold_mask_in || isr != 4'h0;
endmodule : core_model

// ===== reset_counter_interrupt_arbiter_test.sv
`timescale 1ns/1ps
`include "sysint_defs.svh"
module reset_counter_interrupt_arbiter_test;
    logic clk_in = 0, reset_in = 1, low_voltage_in = 0, reset_pin_in = 1, dp_in = 1, dm_in = 0;
    logic stop_in = 0, wake_in = 0, swi_in = 0, run = 0, hold_mask = 0, boundary_in, mask_in, serviced_in;
    logic [15:1] request_in = '0, enable_in = '1;
    logic [15:0] pc_in = 16'h1234, vector_out, stacked_pc_out;
    logic reset_pin_out, reset_pin_oe_out, core_reset_out, bus_unaddressed_out, bus_irq_out, watchdog_tick_out;
    logic clocks_run_out, take_out, stack_upper_index_out, set_mask_out;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0, cmp_count = 0, cyc = 0;

    reset_counter_interrupt_arbiter #(.LONG_COUNT(64)) u_reset_counter_interrupt_arbiter (.clk_in, .reset_in,
        .low_voltage_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe_out, .core_reset_out, .dp_in, .dm_in,
        .bus_unaddressed_out, .bus_irq_out, .watchdog_tick_out, .stop_in, .wake_in, .clocks_run_out, .request_in,
        .enable_in, .boundary_in, .mask_in, .swi_in, .serviced_in, .pc_in, .take_out, .vector_out, .stacked_pc_out,
        .stack_upper_index_out, .set_mask_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    core_model u_core_model (.clk_in, .reset_in, .take_in(take_out), .run_in(run), .hold_mask_in(hold_mask),
        .boundary_out(boundary_in), .serviced_out(serviced_in), .mask_out(mask_in));

    // Clock and hang guard; the ceiling is nearly four times the planned run
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One bus transfer; ready sampled mid-cycle, released on the next edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
                       output logic [31:0] q);
        logic aw, w, ar, done;
        done = 0;
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        while (!done) begin
            @(negedge clk_in);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ar = s_axi_arvalid && s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            r = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk_in);
            if (aw)
                s_axi_awvalid <= 0;
            if (w)
                s_axi_wvalid <= 0;
            if (ar)
                s_axi_arvalid <= 0;
        end
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] q;
        bus(0, a, 0, r, q);
        chk("read data", exp, q);
        chk("read resp", {30'h0, er}, {30'h0, r});
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] q;
        bus(1, a, d, r, q);
        chk("write resp", {30'h0, er}, {30'h0, r});
    endtask : wr

    // Wait for entry, then check what the core is told to fetch and stack
    task automatic take_chk(input logic [15:0] vec, input logic [15:0] pc);
        int t;
        t = 0;
        do begin
            @(negedge clk_in);
            t++;
        end while (take_out !== 1'h1 && t < 200);
        chk("vector", {16'h0, vec}, {16'h0, vector_out});
        chk("stacked pc", {16'h0, pc}, {16'h0, stacked_pc_out});
        chk("upper index", 0, {31'h0, stack_upper_index_out});
        chk("mask at entry", 1, {31'h0, set_mask_out});
        // Let this entry end so the next call cannot see it again
        t = 0;
        while (take_out === 1'h1 && t < 20) begin
            @(negedge clk_in);
            t++;
        end
        @(posedge clk_in);
    endtask : take_chk

    task automatic no_take(input int cycles);
        int seen;
        seen = 0;
        repeat (cycles) begin
            @(negedge clk_in);
            seen += (take_out !== 1'h0);
        end
        chk("entries", 0, seen);
    endtask : no_take

    // Main sequence
    initial begin
        int n, m, v;
        logic [31:0] ctl [5] = '{32'h5, 32'h5, 32'h4, 32'h3, 32'h1};
        int len [5] = '{260, 240, 260, 260, 260};
        logic [31:0] irq [5] = '{1, 0, 0, 0, 0};
        logic [31:0] crst [5] = '{0, 0, 0, 0, 1};
        repeat (20) @(posedge clk_in);
        reset_in <= 0;
        repeat (40) @(negedge clk_in);
        chk("core reset", 0, {31'h0, core_reset_out});
        request_in <= 15'h4D2B;
        // Flags 1,2,4,6 / 9,11,12 / 15 pending; the new levels land only after this step
        rd(`ADDR_STATUS_A, 32'h0000_00AC, `RESP_OKAY);
        rd(`ADDR_STATUS_B, 32'h0000_0034, `RESP_OKAY);
        rd(`ADDR_STATUS_C, 32'h0000_0001, `RESP_OKAY);
        wr(`ADDR_STATUS_A, 32'h0000_00FF, `RESP_OKAY);
        rd(`ADDR_STATUS_A, 32'h0000_00AC, `RESP_OKAY);
        rd(12'h0FC, 32'h0, `RESP_SLVERR);
        wr(12'h0FC, 32'h0, `RESP_SLVERR);
        rd(`ADDR_CONTROL, 32'h0000_0001, `RESP_OKAY);
        // Flags 3 and 9 together, then flag 9 after return
        request_in <= 15'h0104;
        run <= 1;
        take_chk(16'hFFF6, 16'h1233);
        request_in <= 15'h0100;
        take_chk(16'hFFEA, 16'h1233);
        request_in <= 15'h0001;
        hold_mask <= 1;
        no_take(40);
        hold_mask <= 0;
        enable_in <= 15'h7FFE;
        no_take(40);
        enable_in <= '1;
        take_chk(16'hFFFA, 16'h1233);
        request_in <= '0;
        hold_mask <= 1;
        swi_in <= 1;
        take_chk(`VEC_SWI, 16'h1234);
        swi_in <= 0;
        hold_mask <= 0;
        run <= 0;
        // Low voltage: pin phase, then core tail
        low_voltage_in <= 1;
        n = 0;
        m = 0;
        v = 0;
        repeat (300) begin
            @(negedge clk_in);
            n += (reset_pin_oe_out === 1'h1 && reset_pin_out === 1'h0);
            m += (reset_pin_oe_out === 1'h0 && core_reset_out === 1'h1);
            v += (core_reset_out === 1'h1 && vector_out !== `VEC_RESET);
            if (n > 4)
                low_voltage_in <= 0;
        end
        chk("pin low cycles", 64, n);
        chk("tail cycles", 32, m);
        chk("reset vector misses", 0, v);
        rd(`ADDR_RESET_CAUSE, 32'h0000_0002, `RESP_OKAY);
        rd(`ADDR_RESET_CAUSE, 32'h0, `RESP_OKAY);
        // Bus reset: routed, too short, module off, chip reset off, chip reset
        foreach (ctl[i]) begin
            wr(`ADDR_CONTROL, ctl[i], `RESP_OKAY);
            dp_in <= 0;
            repeat (len[i]) @(posedge clk_in);
            @(negedge clk_in);
            chk("bus irq", irq[i], {31'h0, bus_irq_out});
            chk("core reset", crst[i], {31'h0, core_reset_out});
            @(posedge clk_in);
            dp_in <= 1;
            // Long enough for a chip reset's pin and tail phases to finish
            repeat (80) @(posedge clk_in);
        end
        rd(`ADDR_RESET_CAUSE, 32'h0000_0004, `RESP_OKAY);
        chk("unaddressed", 1, {31'h0, bus_unaddressed_out});
        // Stop recovery, short then long
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_CONTROL, k ? 32'h1 : 32'h9, `RESP_OKAY);
            stop_in <= 1;
            @(posedge clk_in);
            stop_in <= 0;
            repeat (5) @(negedge clk_in);
            chk("clocks stopped", 0, {31'h0, clocks_run_out});
            @(posedge clk_in);
            wake_in <= 1;
            @(posedge clk_in);
            wake_in <= 0;
            n = 0;
            while (clocks_run_out !== 1'h1 && n < 5000) begin
                @(negedge clk_in);
                n++;
            end
            m = k ? 4096 : 32;
            chk("recovery in range", 1, {31'h0, n >= m && n <= m + 8});
        end
        // Overflow spacing, with an external pin pulse in between
        n = 0;
        while (watchdog_tick_out !== 1'h1 && n < 5000) begin
            @(negedge clk_in);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_in);
            reset_pin_in <= !(n >= 100 && n < 110);
            @(negedge clk_in);
            n++;
        end while (watchdog_tick_out !== 1'h1 && n < 5000);
        chk("tick spacing", 4096, n);
        wrap_up();
    end
endmodule : reset_counter_interrupt_arbiter_test
